// File: hw/uarb_pkg.sv
// package: constants and types of the receive-break / address-match block
//==============================================================
package uarb_pkg;

  //==============================================================
  // register byte offsets
  localparam logic [7:0] UARB_OFS_HOLD   = 8'h00;
  localparam logic [7:0] UARB_OFS_STAT   = 8'h04;
  localparam logic [7:0] UARB_OFS_MASK   = 8'h08;
  localparam logic [7:0] UARB_OFS_CTRL   = 8'h0C;
  localparam logic [7:0] UARB_OFS_SHARED = 8'h10;
  localparam logic [7:0] UARB_OFS_MODE   = 8'h14;

  //==============================================================
  // status bit positions
  localparam int UARB_ST_FULL  = 0;
  localparam int UARB_ST_OVR   = 1;
  localparam int UARB_ST_BRK   = 2;
  localparam int UARB_ST_FERR  = 3;
  localparam int UARB_ST_MATCH = 4;
  localparam int UARB_ST_W     = 5;

  // control/format field positions
  localparam int UARB_CF_SEL   = 7;
  localparam int UARB_CF_SHSEL = 6;

  //==============================================================
  // reset values
  localparam logic [6:0] UARB_CTRL_RST = 7'h00;
  localparam logic [6:0] UARB_FMT_RST  = 7'h60;
  localparam logic [7:0] UARB_BYTE_RST = 8'h00;

  //==============================================================
  // oversampling and divisor table
  localparam int          UARB_OVS      = 16;
  localparam logic [3:0]  UARB_MID_TICK = 4'h7;
  localparam logic [3:0]  UARB_EXT_CODE = 4'hF;
  localparam logic [16:0] UARB_DIV [15] = '{
    17'h12000, 17'h08302, 17'h06B10, 17'h06000, 17'h03000,
    17'h01800, 17'h00C00, 17'h00800, 17'h00600, 17'h00400,
    17'h00300, 17'h00200, 17'h00180, 17'h000C0, 17'h00060};

  //==============================================================
  // carriers
  typedef struct packed {
    logic       two_stop;
    logic       echo;
    logic [3:0] baud_sel;
  } uarb_ctrl_t;

  typedef struct packed {
    logic [1:0] data_len;
    logic [1:0] par_mode;
    logic       par_en;
    logic       dtr;
    logic       rts;
  } uarb_fmt_t;

  typedef struct packed {
    logic [7:0] data;
    logic       marker;
    logic       ferr;
  } uarb_rxchar_t;

endpackage

// File: hw/uarb_baud.sv
// baud tick source: crystal divisor or external receive clock
`timescale 1ns/100ps
module uarb_baud
  import uarb_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       crystal_in,
  input  wire logic       rx_clk_ext,
  input  wire logic [3:0] baud_sel,
  output logic            tick16
);

  //==============================================================
  // three-stage synchronisers, change accepted once stages 2 and 3 agree
  logic [1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r;
  logic [1:0] pin_in;
  assign pin_in = {rx_clk_ext, crystal_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[gi]    <= 1'b0;
          s2_r[gi]    <= 1'b0;
          s3_r[gi]    <= 1'b0;
          lvl_r[gi]   <= 1'b0;
          lvl_d_r[gi] <= 1'b0;
        end else begin
          s1_r[gi]    <= pin_in[gi];
          s2_r[gi]    <= s1_r[gi];
          s3_r[gi]    <= s2_r[gi];
          lvl_d_r[gi] <= lvl_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  logic xtal_rise, rxc_rise;
  assign xtal_rise = lvl_r[0] & ~lvl_d_r[0];
  assign rxc_rise  = lvl_r[1] & ~lvl_d_r[1];

  //==============================================================
  // divider: crystal edges per oversample tick is divisor / 16
  logic [12:0] cnt_r;
  logic [12:0] limit;
  assign limit = (baud_sel == UARB_EXT_CODE) ? 13'h0001
               : 13'((UARB_DIV[baud_sel] / UARB_OVS) - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 13'h0000;
      tick16 <= 1'b0;
    end else if (baud_sel == UARB_EXT_CODE) begin
      cnt_r  <= 13'h0000;
      tick16 <= rxc_rise;
    end else if (xtal_rise) begin
      tick16 <= (cnt_r >= limit);
      cnt_r  <= (cnt_r >= limit) ? 13'h0000 : cnt_r + 13'h0001;
    end else begin
      tick16 <= 1'b0;
    end
  end

endmodule

// File: hw/uarb_rx.sv
// receive shifter with break detection
`timescale 1ns/100ps
module uarb_rx
  import uarb_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         rxd,
  input  wire logic         tick16,
  input  wire uarb_fmt_t    fmt,
  output uarb_rxchar_t      rx_char,
  output logic              rx_done,
  output logic              rx_break,
  output logic              in_break
);

  typedef enum logic [2:0] {IDLE, START, DATA, PARB, STOP, BRK} uarb_rxst_t;

  // rx line synchroniser, same agreement filter as the clock inputs
  logic s1_r, s2_r, s3_r, line_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r   <= 1'b1;
      s2_r   <= 1'b1;
      s3_r   <= 1'b1;
      line_r <= 1'b1;
    end else begin
      s1_r <= rxd;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        line_r <= s3_r;
      end
    end
  end

  uarb_rxst_t st_r;
  logic [3:0] ph_r;
  logic [2:0] bit_r;
  logic [7:0] sh_r;
  logic       mk_r;
  logic [2:0] last_bit;
  assign last_bit = {1'b1, fmt.data_len} ;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= IDLE;
      ph_r     <= 4'h0;
      bit_r    <= 3'h0;
      sh_r     <= 8'h00;
      mk_r     <= 1'b0;
      rx_char  <= '0;
      rx_done  <= 1'b0;
      rx_break <= 1'b0;
    end else begin
      rx_done  <= 1'b0;
      rx_break <= 1'b0;
      if (st_r == BRK) begin
        if (line_r) begin
          st_r <= IDLE;
        end
      end else if (tick16) begin
        ph_r <= ph_r + 4'h1;
        unique case (st_r)
          IDLE: begin
            ph_r <= 4'h0;
            if (!line_r) begin
              st_r <= START;
            end
          end
          START: if (ph_r == UARB_MID_TICK) begin
            ph_r  <= 4'h0;
            bit_r <= 3'h0;
            sh_r  <= 8'h00;
            mk_r  <= 1'b0;
            st_r  <= line_r ? IDLE : DATA;
          end
          DATA: if (ph_r == 4'hF) begin
            sh_r[bit_r] <= line_r;
            bit_r       <= bit_r + 3'h1;
            if (bit_r == last_bit) begin
              st_r <= fmt.par_en ? PARB : STOP;
            end
          end
          PARB: if (ph_r == 4'hF) begin
            mk_r <= line_r;
            st_r <= STOP;
          end
          STOP: if (ph_r == 4'hF) begin
            if (!line_r && sh_r == 8'h00 && !mk_r) begin
              rx_break <= 1'b1;
              st_r     <= BRK;
            end else begin
              rx_char <= '{data: sh_r, marker: mk_r, ferr: ~line_r};
              rx_done <= 1'b1;
              st_r    <= IDLE;
            end
          end
          BRK: st_r <= BRK;
        endcase
      end
    end
  end

  assign in_break = (st_r == BRK);

endmodule

// File: hw/uarb_top.sv
// receive channel with break handling, address match and APB registers
`timescale 1ns/100ps
module uarb_top
  import uarb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        crystal_in,
  input  wire logic        rx_clk_ext,
  input  wire logic        rxd,
  output logic             dtr_out,
  output logic             rts_out
);

  //==============================================================
  // bus phase decode
  logic acc, wr_en, rd_en, hit;
  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;
  assign hit   = (paddr == UARB_OFS_HOLD) || (paddr == UARB_OFS_STAT) ||
                 (paddr == UARB_OFS_MASK) || (paddr == UARB_OFS_CTRL) ||
                 (paddr == UARB_OFS_SHARED) || (paddr == UARB_OFS_MODE);

  //==============================================================
  // registers
  uarb_ctrl_t              ctrl_r;
  logic                    shsel_r;
  uarb_fmt_t               fmt_r;
  logic [7:0]              match_value_reg;
  logic [7:0]              irq_vector_reg;
  logic [7:0]              rx_holding_reg;
  logic                    rx_full_flag;
  logic [UARB_ST_W-1:0]    irq_status_reg;
  logic [UARB_ST_W-1:0]    irq_mask_r;
  logic                    cmp_en_r;
  logic                    cmp_active_r;

  logic         tick16, rx_done, rx_break, in_break;
  uarb_rxchar_t rx_char;

  uarb_baud u_baud (
    .pclk       (pclk),
    .presetn    (presetn),
    .crystal_in (crystal_in),
    .rx_clk_ext (rx_clk_ext),
    .baud_sel   (ctrl_r.baud_sel),
    .tick16     (tick16)
  );

  uarb_rx u_rx (
    .pclk     (pclk),
    .presetn  (presetn),
    .rxd      (rxd),
    .tick16   (tick16),
    .fmt      (fmt_r),
    .rx_char  (rx_char),
    .rx_done  (rx_done),
    .rx_break (rx_break),
    .in_break (in_break)
  );

  //==============================================================
  // received character routing
  logic addr_hit, deliver, overrun, hold_rd;
  assign addr_hit = rx_done & cmp_active_r & rx_char.marker &
                    (rx_char.data == match_value_reg);
  // while armed, compare mode drops every non-matching character silently
  assign deliver  = rx_done & (~cmp_active_r | addr_hit);
  assign overrun  = deliver & rx_full_flag;
  assign hold_rd  = rd_en & (paddr == UARB_OFS_HOLD);

  logic wr_ctrl, wr_shared, wr_match;
  assign wr_ctrl   = wr_en & (paddr == UARB_OFS_CTRL);
  assign wr_shared = wr_en & (paddr == UARB_OFS_SHARED);
  assign wr_match  = wr_shared & ~shsel_r;

  //==============================================================
  // control/format register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= uarb_ctrl_t'(UARB_CTRL_RST[5:0]);
      shsel_r <= UARB_CTRL_RST[UARB_CF_SHSEL];
      fmt_r   <= uarb_fmt_t'(UARB_FMT_RST);
    end else if (wr_ctrl) begin
      if (pwdata[UARB_CF_SEL]) begin
        fmt_r <= uarb_fmt_t'(pwdata[6:0]);
      end else begin
        ctrl_r  <= uarb_ctrl_t'(pwdata[5:0]);
        shsel_r <= pwdata[UARB_CF_SHSEL];
      end
    end
  end

  //==============================================================
  // shared location: match value or interrupt vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_value_reg <= UARB_BYTE_RST;
      irq_vector_reg  <= UARB_BYTE_RST;
    end else if (wr_shared) begin
      if (shsel_r) begin
        irq_vector_reg <= pwdata[7:0];
      end else begin
        match_value_reg <= pwdata[7:0];
      end
    end
  end

  //==============================================================
  // compare mode: armed by a match value write, dropped on a hit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_en_r     <= 1'b0;
      cmp_active_r <= 1'b0;
    end else begin
      if (wr_en && paddr == UARB_OFS_MODE) begin
        cmp_en_r <= pwdata[0];
      end
      // re-arm wins over a hit in the same cycle
      if (wr_match && cmp_en_r) begin
        cmp_active_r <= 1'b1;
      end else if (wr_en && paddr == UARB_OFS_MODE && !pwdata[0]) begin
        cmp_active_r <= 1'b0;
      end else if (addr_hit) begin
        cmp_active_r <= 1'b0;
      end
    end
  end

  //==============================================================
  // holding register and full flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_holding_reg <= UARB_BYTE_RST;
      rx_full_flag   <= 1'b0;
    end else begin
      if (deliver && !rx_full_flag) begin
        rx_holding_reg <= rx_char.data;
      end
      // break never reaches here, so full is never set by it
      if (deliver && !rx_full_flag) begin
        rx_full_flag <= 1'b1;
      end else if (hold_rd) begin
        rx_full_flag <= 1'b0;
      end
    end
  end

  //==============================================================
  // sticky status, write one to clear, new events win
  logic [UARB_ST_W-1:0] st_set, st_clr;
  always_comb begin
    st_set = '0;
    st_clr = '0;
    st_set[UARB_ST_FULL]  = deliver & ~rx_full_flag;
    st_set[UARB_ST_OVR]   = overrun;
    st_set[UARB_ST_BRK]   = rx_break;
    st_set[UARB_ST_FERR]  = deliver & ~rx_full_flag & rx_char.ferr;
    st_set[UARB_ST_MATCH] = addr_hit;
    if (wr_en && paddr == UARB_OFS_STAT) begin
      st_clr = pwdata[UARB_ST_W-1:0];
    end
    if (hold_rd) begin
      st_clr[UARB_ST_BRK]  = 1'b1;
      st_clr[UARB_ST_FULL] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
      irq_mask_r     <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~st_clr) | st_set;
      if (wr_en && paddr == UARB_OFS_MASK) begin
        irq_mask_r <= pwdata[UARB_ST_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_r);
    end
  end

  //==============================================================
  // line control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
    end else begin
      dtr_out <= fmt_r.dtr;
      rts_out <= fmt_r.rts;
    end
  end

  //==============================================================
  // apb slave: one wait state so that read data comes from a flop
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      UARB_OFS_HOLD:   rd_mux[7:0] = rx_holding_reg;
      UARB_OFS_STAT:   rd_mux[UARB_ST_W-1:0] = irq_status_reg;
      UARB_OFS_MASK:   rd_mux[UARB_ST_W-1:0] = irq_mask_r;
      UARB_OFS_CTRL:   rd_mux[13:0] = {fmt_r, shsel_r, ctrl_r};
      UARB_OFS_SHARED: rd_mux[7:0] = shsel_r ? irq_vector_reg : match_value_reg;
      UARB_OFS_MODE:   rd_mux[3:0] = {in_break, rx_full_flag, cmp_active_r, cmp_en_r};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (psel && penable && !pready) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule

// File: dv/uarb_top_chk.sv
// checker: port-level assertions for the receive channel
`timescale 1ns/100ps
module uarb_top_chk
  import uarb_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        dtr_out,
  input wire logic        rts_out
);
  //==============================================================
  // helper: shadow of the mask, taken only on completed writes
  logic       wr_w;
  logic [4:0] mask_r;
  assign wr_w = psel & penable & pready & pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 5'h00;
    end else if (wr_w && paddr == UARB_OFS_MASK) begin
      mask_r <= pwdata[4:0];
    end
  end

  //==============================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_unmapped: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > UARB_OFS_MODE))
    else $error("pslverr does not match address map");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_hold_width: assert property (pready && !pwrite && paddr == UARB_OFS_HOLD |-> prdata[31:8] == 24'h0)
    else $error("holding read has upper bits set");
  a_fmt_pins: assert property (
    wr_w && paddr == UARB_OFS_CTRL && pwdata[7] |-> ##2 {dtr_out, rts_out} == $past(pwdata[1:0], 2))
    else $error("format write did not reach pins");
  a_ctrl_pins: assert property (
    wr_w && paddr == UARB_OFS_CTRL && !pwdata[7] |=> $stable({dtr_out, rts_out}))
    else $error("control write changed format pins");
  a_irq_masked: assert property (mask_r == 5'h00 && $past(mask_r) == 5'h00 |-> !irq)
    else $error("irq high with mask clear");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_shared: cover property (wr_w && paddr == UARB_OFS_SHARED);
endmodule

// File: dv/uarb_line_model.sv
// model of the master station driving the serial line
`timescale 1ns/100ps
module uarb_line_model (
  output logic rxd
);
  initial rxd = 1'b1;
  // idle high first so a preceding break is ended by a stop level
  task automatic send(input logic [7:0] d, input logic mk, input int bit_ns);
    logic [10:0] f;
    f = {1'b1, mk, d, 1'b0};
    rxd = 1'b1;
    #(2 * bit_ns);
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      #(bit_ns);
    end
  endtask
  // line stays low until the next send
  task automatic brk(input int bit_ns);
    rxd = 1'b0;
    #(12 * bit_ns);
  endtask
endmodule

// File: dv/uarb_rx_break_addr_match_test.sv
// testbench: register, break and address match scenarios
`timescale 1ns/100ps
module uarb_rx_break_addr_match_test;
  import uarb_pkg::*;
  localparam int B15 = 2560;
  localparam int B14 = 15360;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic        crystal_in, rx_clk_ext, rxd, pready, pslverr, irq, dtr_out, rts_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_fail, num_checks;

  uarb_line_model M (.rxd(rxd));
  uarb_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .crystal_in(crystal_in), .rx_clk_ext(rx_clk_ext), .rxd(rxd), .dtr_out(dtr_out), .rts_out(rts_out));

  //==============================================================
  // clocks and watchdog
  initial begin pclk = 0; forever #20 pclk = ~pclk; end
  initial begin crystal_in = 0; forever #80 crystal_in = ~crystal_in; end
  initial begin rx_clk_ext = 0; #37; forever #80 rx_clk_ext = ~rx_clk_ext; end
  initial begin repeat (60000) @(posedge pclk); n_fail++; give_verdict; end

  //==============================================================
  // tasks
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); xfer(1, a, d); endtask
  task rd(input logic [7:0] a, input logic [31:0] exp); xfer(0, a, 0); chk("read", exp, q); endtask
  task irq_is(input logic v); repeat (8) @(posedge pclk); chk("irq", {31'h0, v}, {31'h0, irq}); endtask

  //==============================================================
  // scenarios
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; n_fail = 0; num_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd(UARB_OFS_CTRL, 32'h3000);
    rd(8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    wr(UARB_OFS_CTRL, 32'hE7);
    wr(UARB_OFS_CTRL, 32'h0F);
    rd(UARB_OFS_CTRL, 32'h338F);
    chk("pins", 32'h3, {30'h0, dtr_out, rts_out});
    wr(UARB_OFS_SHARED, 32'h5A);
    wr(UARB_OFS_CTRL, 32'h4F);
    wr(UARB_OFS_SHARED, 32'hC3);
    rd(UARB_OFS_SHARED, 32'hC3);
    wr(UARB_OFS_CTRL, 32'h0F);
    rd(UARB_OFS_SHARED, 32'h5A);
    // plain character, mask and clear of its interrupt
    wr(UARB_OFS_MASK, 32'h1F);
    M.send(8'h3C, 1'b0, B15);
    irq_is(1);
    rd(UARB_OFS_STAT, 32'h01);
    wr(UARB_OFS_MASK, 32'h00);
    irq_is(0);
    wr(UARB_OFS_MASK, 32'h1F);
    irq_is(1);
    wr(UARB_OFS_STAT, 32'h01);
    irq_is(0);
    rd(UARB_OFS_HOLD, 32'h3C);
    // break, then a normal character
    M.brk(B15);
    irq_is(1);
    xfer(0, UARB_OFS_STAT, 0);
    chk("stat", 32'h04, q & 32'h05);
    rd(UARB_OFS_MODE, 32'h08);
    M.send(8'hA5, 1'b0, B15);
    xfer(0, UARB_OFS_STAT, 0);
    chk("stat", 32'h05, q & 32'h05);
    rd(UARB_OFS_HOLD, 32'hA5);
    xfer(0, UARB_OFS_STAT, 0);
    chk("stat", 32'h00, q & 32'h05);
    wr(UARB_OFS_STAT, 32'h1F);
    // compare mode
    wr(UARB_OFS_MODE, 32'h01);
    wr(UARB_OFS_SHARED, 32'h42);
    rd(UARB_OFS_MODE, 32'h03);
    M.send(8'h42, 1'b0, B15);
    M.send(8'h17, 1'b1, B15);
    irq_is(0);
    rd(UARB_OFS_STAT, 32'h00);
    M.send(8'h42, 1'b1, B15);
    irq_is(1);
    rd(UARB_OFS_STAT, 32'h11);
    rd(UARB_OFS_MODE, 32'h05);
    rd(UARB_OFS_HOLD, 32'h42);
    wr(UARB_OFS_STAT, 32'h10);
    M.send(8'h99, 1'b0, B15);
    rd(UARB_OFS_HOLD, 32'h99);
    wr(UARB_OFS_SHARED, 32'h42);
    rd(UARB_OFS_MODE, 32'h03);
    M.send(8'h77, 1'b0, B15);
    irq_is(0);
    rd(UARB_OFS_STAT, 32'h00);
    wr(UARB_OFS_MODE, 32'h00);
    // overrun: second character lost, first one kept
    M.send(8'h11, 1'b0, B15);
    M.send(8'h22, 1'b0, B15);
    rd(UARB_OFS_STAT, 32'h03);
    rd(UARB_OFS_HOLD, 32'h11);
    // crystal divisor code
    wr(UARB_OFS_CTRL, 32'h0E);
    M.send(8'hE1, 1'b0, B14);
    repeat (8) @(posedge pclk);
    rd(UARB_OFS_HOLD, 32'hE1);
    give_verdict;
  end
endmodule

bind uarb_top uarb_top_chk CHK (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .dtr_out(dtr_out), .rts_out(rts_out));
